// ---- src/cpurs_core_regs.sv ----
// Contract
// - the core holds sixteen 32-bit general registers, a 32-bit instruction pointer and an 8-bit flags byte.
// - control registers change only in supervisor mode and, apart from the reset vector load of the alternate stack pointer, only through privileged commands.
// - multiply-accumulate works on 16x16 and 32x32 operands into a 32-bit accumulator.
// - after reset the instruction pointer is loaded from memory word 0x4 before any command runs.
// - after reset the alternate stack pointer is loaded from memory word 0x0.
// - reset clears the exception table base to zero.
// - reset clears the core configuration word to zero.
// - reset loads data registers zero and one with fixed identification codes.
// - the other general registers and the flags byte are not defined by reset.
// - peripheral registers update on the bus clock enable, fast port registers on every core clock.
`timescale 1ns/1ns
module cpurs_core_regs #(
   parameter int GPR_NUM = cpurs_pkg::NGPR,
   parameter int W       = cpurs_pkg::XLEN
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  cmd_valid,
   input  wire cpurs_pkg::cpurs_op_e  cmd_op,
   input  wire logic [3:0]            cmd_sel,
   input  wire logic [W-1:0]          cmd_wdata,
   input  wire logic                  cmd_sub,
   output logic                       cmd_ready,
   output logic                       rsp_valid,
   output logic [W-1:0]               rsp_data,
   output logic                       priv_fault,
   output logic                       mem_rd,
   output logic [W-1:0]               mem_addr,
   input  wire logic                  mem_ack,
   input  wire logic [W-1:0]          mem_rdata,
   output logic                       core_running,
   output logic                       supervisor,
   output logic [W-1:0]               ip_value,
   output logic [W-1:0]               fast_port,
   output logic [W-1:0]               periph_reg
);

   typedef enum logic [1:0] {ST_SP, ST_IP, ST_RUN} cpurs_st_e;

   // ======================================================================
   // registers
   cpurs_st_e                  st_r;
   cpurs_st_e                  st_nxt;
   logic [W-1:0]               gpr_r [GPR_NUM];
   logic [W-1:0]               ip_r;
   logic [cpurs_pkg::FLAGS_W-1:0] flags_r;
   logic [cpurs_pkg::STATE_W-1:0] state_word_r;
   logic [W-1:0]               alt_sp_r;
   logic [W-1:0]               excb_r;
   logic [W-1:0]               cfg_r;
   logic [W-1:0]               fast_r;
   logic [W-1:0]               periph_r;
   logic [W-1:0]               pend_data_r;
   logic                       pend_r;
   logic                       pend_nxt;
   logic                       bus_en_r;
   logic                       ready_r;
   logic                       ready_nxt;
   logic                       rsp_valid_r;
   logic [W-1:0]               rsp_data_r;
   logic                       fault_r;
   logic                       mem_rd_r;
   logic [W-1:0]               mem_addr_r;
   logic                       run_r;
   logic [W-1:0]               acc;

   // ======================================================================
   // command decode
   logic         take;
   logic         is_priv;
   logic         supv;
   logic         fault;
   logic         do_op;
   logic         is_read;
   logic         wr_periph;
   logic         fetch_ack;
   logic [W-1:0] gpr_rd;
   logic [W-1:0] ctrl_rd;
   logic [W-1:0] rd_mux;
   logic [W-1:0] prod16;

   assign take    = cmd_valid && ready_r;
   assign supv    = state_word_r[cpurs_pkg::SUPV_BIT];
   assign is_priv = cmd_op == cpurs_pkg::OP_RD_CTRL || cmd_op == cpurs_pkg::OP_WR_CTRL;
   assign fault   = take && is_priv && !supv;
   assign do_op   = take && !fault;
   assign is_read = cmd_op == cpurs_pkg::OP_RD_GPR   || cmd_op == cpurs_pkg::OP_RD_IP   ||
                    cmd_op == cpurs_pkg::OP_RD_FLAGS || cmd_op == cpurs_pkg::OP_RD_CTRL ||
                    cmd_op == cpurs_pkg::OP_RD_ACC   || cmd_op == cpurs_pkg::OP_RD_FAST ||
                    cmd_op == cpurs_pkg::OP_RD_PERIPH;
   assign wr_periph = do_op && cmd_op == cpurs_pkg::OP_WR_PERIPH;
   assign fetch_ack = mem_rd_r && mem_ack;
   assign gpr_rd    = gpr_r[cmd_sel];
   assign prod16    = gpr_rd[cpurs_pkg::HALF_W-1:0] * cmd_wdata[cpurs_pkg::HALF_W-1:0];

   assign ctrl_rd = cmd_sel[1:0] == cpurs_pkg::CSEL_STATE ? {16'h0000, state_word_r} :
                    cmd_sel[1:0] == cpurs_pkg::CSEL_ALTSP ? alt_sp_r :
                    cmd_sel[1:0] == cpurs_pkg::CSEL_EXCB  ? excb_r : cfg_r;

   assign rd_mux = cmd_op == cpurs_pkg::OP_RD_GPR   ? gpr_rd :
                   cmd_op == cpurs_pkg::OP_RD_IP    ? ip_r :
                   cmd_op == cpurs_pkg::OP_RD_FLAGS ? {24'h000000, flags_r} :
                   cmd_op == cpurs_pkg::OP_RD_CTRL  ? ctrl_rd :
                   cmd_op == cpurs_pkg::OP_RD_ACC   ? acc :
                   cmd_op == cpurs_pkg::OP_RD_FAST  ? fast_r : periph_r;

   // ======================================================================
   // reset vector fetch sequence
   assign st_nxt = (st_r == ST_SP && fetch_ack) ? ST_IP :
                   (st_r == ST_IP && fetch_ack) ? ST_RUN : st_r;

   assign pend_nxt  = pend_r ? !bus_en_r : wr_periph;
   assign ready_nxt = st_nxt == ST_RUN && !pend_nxt;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r       <= ST_SP;
         mem_rd_r   <= 1'b1;
         mem_addr_r <= cpurs_pkg::VEC_SP_ADDR;
         run_r      <= 1'b0;
         ready_r    <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         mem_rd_r   <= st_nxt != ST_RUN;
         mem_addr_r <= st_nxt == ST_SP ? cpurs_pkg::VEC_SP_ADDR : cpurs_pkg::VEC_IP_ADDR;
         run_r      <= st_nxt == ST_RUN;
         ready_r    <= ready_nxt;
      end
   end

   // ======================================================================
   // general registers, pointer and flags
   always_ff @(posedge clk_sys) begin
      // others keep whatever they held
      if (rst) begin
         gpr_r[cpurs_pkg::DATA0_IX] <= cpurs_pkg::ID_WORD0;
         gpr_r[cpurs_pkg::DATA1_IX] <= cpurs_pkg::ID_WORD1;
      end else if (do_op && cmd_op == cpurs_pkg::OP_WR_GPR) begin
         gpr_r[cmd_sel] <= cmd_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (st_r == ST_IP && fetch_ack) begin
         ip_r <= mem_rdata;
      end else if (do_op && cmd_op == cpurs_pkg::OP_WR_IP) begin
         ip_r <= cmd_wdata;
      end
      if (do_op && cmd_op == cpurs_pkg::OP_WR_FLAGS) begin
         flags_r <= cmd_wdata[cpurs_pkg::FLAGS_W-1:0];
      end
   end

   // ======================================================================
   // supervisor control registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_word_r <= cpurs_pkg::STATE_RST;
         excb_r       <= cpurs_pkg::ZERO_WORD;
         cfg_r        <= cpurs_pkg::ZERO_WORD;
      end else if (do_op && cmd_op == cpurs_pkg::OP_WR_CTRL) begin
         unique case (cmd_sel[1:0])
            cpurs_pkg::CSEL_STATE: state_word_r <= cmd_wdata[cpurs_pkg::STATE_W-1:0];
            cpurs_pkg::CSEL_EXCB:  excb_r       <= cmd_wdata;
            cpurs_pkg::CSEL_CFG:   cfg_r        <= cmd_wdata;
            cpurs_pkg::CSEL_ALTSP: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (st_r == ST_SP && fetch_ack) begin
         alt_sp_r <= mem_rdata;
      end else if (do_op && cmd_op == cpurs_pkg::OP_WR_CTRL &&
                   cmd_sel[1:0] == cpurs_pkg::CSEL_ALTSP) begin
         alt_sp_r <= cmd_wdata;
      end
   end

   // ======================================================================
   // fast port and bus-clocked peripheral register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fast_r      <= cpurs_pkg::ZERO_WORD;
         periph_r    <= cpurs_pkg::ZERO_WORD;
         pend_data_r <= cpurs_pkg::ZERO_WORD;
         pend_r      <= 1'b0;
         bus_en_r    <= 1'b0;
      end else begin
         bus_en_r <= !bus_en_r;
         pend_r   <= pend_nxt;
         if (do_op && cmd_op == cpurs_pkg::OP_WR_FAST) begin
            fast_r <= cmd_wdata;
         end
         if (wr_periph) begin
            pend_data_r <= cmd_wdata;
         end
         if (pend_r && bus_en_r) begin
            periph_r <= pend_data_r;
         end
      end
   end

   // ======================================================================
   // answers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= cpurs_pkg::ZERO_WORD;
         fault_r     <= 1'b0;
      end else begin
         rsp_valid_r <= do_op && is_read;
         fault_r     <= fault;
         if (do_op && is_read) begin
            rsp_data_r <= rd_mux;
         end
      end
   end

   // ======================================================================
   // multiply-accumulate
   cpurs_mac #(.W(W)) u_mac (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .mac_en    (do_op && (cmd_op == cpurs_pkg::OP_MAC16 || cmd_op == cpurs_pkg::OP_MAC32)),
      .wide      (cmd_op == cpurs_pkg::OP_MAC32),
      .sub       (cmd_sub),
      .op_a      (gpr_rd),
      .op_b      (cmd_wdata),
      .load      (do_op && cmd_op == cpurs_pkg::OP_WR_ACC),
      .load_data (cmd_wdata),
      .acc       (acc)
   );

   assign cmd_ready    = ready_r;
   assign rsp_valid    = rsp_valid_r;
   assign rsp_data     = rsp_data_r;
   assign priv_fault   = fault_r;
   assign mem_rd       = mem_rd_r;
   assign mem_addr     = mem_addr_r;
   assign core_running = run_r;
   assign supervisor   = state_word_r[cpurs_pkg::SUPV_BIT];
   assign ip_value     = ip_r;
   assign fast_port    = fast_r;
   assign periph_reg   = periph_r;

   // ======================================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_ip_vector: assert property (
      (st_r == ST_IP && mem_rd_r && mem_ack) |=> (ip_r == $past(mem_rdata) && run_r))
      else $error("ip not loaded from vector word");
   chk_no_early_cmd: assert property (!run_r |-> !ready_r)
      else $error("command accepted before vector fetch");
   chk_sp_vector: assert property (
      (st_r == ST_SP && mem_rd_r && mem_ack) |=>
      (alt_sp_r == $past(mem_rdata) && mem_addr_r == cpurs_pkg::VEC_IP_ADDR))
      else $error("stack pointer not loaded from vector word");
   chk_reset_ctrl: assert property ($past(rst) |-> (excb_r == cpurs_pkg::ZERO_WORD &&
      cfg_r == cpurs_pkg::ZERO_WORD && supv && mem_addr_r == cpurs_pkg::VEC_SP_ADDR))
      else $error("control registers wrong after reset");
   chk_reset_ident: assert property ($past(rst) |->
      (gpr_r[cpurs_pkg::DATA0_IX] == cpurs_pkg::ID_WORD0 &&
       gpr_r[cpurs_pkg::DATA1_IX] == cpurs_pkg::ID_WORD1))
      else $error("identification words wrong after reset");
   chk_user_blocked: assert property ((take && is_priv && !supv) |=>
      (fault_r && !rsp_valid_r && $stable(excb_r) && $stable(cfg_r) &&
       $stable(state_word_r) && $stable(alt_sp_r)))
      else $error("privileged command acted in user mode");
   chk_supv_write: assert property ((do_op && cmd_op == cpurs_pkg::OP_WR_CTRL &&
      cmd_sel[1:0] == cpurs_pkg::CSEL_CFG) |=> (cfg_r == $past(cmd_wdata) && !fault_r))
      else $error("supervisor control write lost");
   chk_periph_slow: assert property ((periph_r != $past(periph_r)) |-> $past(bus_en_r && pend_r))
      else $error("peripheral register changed off bus enable");
   chk_fast_now: assert property ((do_op && cmd_op == cpurs_pkg::OP_WR_FAST) |=>
      fast_r == $past(cmd_wdata))
      else $error("fast port write delayed");
   chk_mac_short: assert property ((do_op && cmd_op == cpurs_pkg::OP_MAC16 && !cmd_sub) |=>
      acc == $past(acc) + $past(prod16))
      else $error("16x16 accumulate wrong");
   chk_gpr_write: assert property ((do_op && cmd_op == cpurs_pkg::OP_WR_GPR) |=>
      gpr_r[$past(cmd_sel)] == $past(cmd_wdata))
      else $error("general register write lost");

endmodule

// ---- src/cpurs_pkg.sv ----
package cpurs_pkg;

   // ======================================================================
   // widths and counts
   localparam int XLEN     = 32;
   localparam int NGPR     = 16;
   localparam int FLAGS_W  = 8;
   localparam int STATE_W  = 16;
   localparam int HALF_W   = 16;
   localparam int DATA0_IX = 0;
   localparam int DATA1_IX = 1;

   // ======================================================================
   // reset vector addresses
   localparam logic [31:0] VEC_SP_ADDR = 32'h0000_0000;
   localparam logic [31:0] VEC_IP_ADDR = 32'h0000_0004;

   // ======================================================================
   // reset values
   localparam logic [15:0] STATE_RST  = 16'h0027;
   localparam int          SUPV_BIT   = 5;
   localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
   // identification codes: values are arbitrary
   localparam logic [31:0] ID_WORD0   = 32'h5a5a_0001;
   localparam logic [31:0] ID_WORD1   = 32'h0000_1111;

   // ======================================================================
   // control register selects
   localparam logic [1:0] CSEL_STATE = 2'h0;
   localparam logic [1:0] CSEL_ALTSP = 2'h1;
   localparam logic [1:0] CSEL_EXCB  = 2'h2;
   localparam logic [1:0] CSEL_CFG   = 2'h3;

   // ======================================================================
   // commands
   typedef enum logic [3:0] {
      OP_RD_GPR, OP_WR_GPR, OP_RD_IP, OP_WR_IP,
      OP_RD_FLAGS, OP_WR_FLAGS, OP_RD_CTRL, OP_WR_CTRL,
      OP_MAC16, OP_MAC32, OP_RD_ACC, OP_WR_ACC,
      OP_RD_FAST, OP_WR_FAST, OP_RD_PERIPH, OP_WR_PERIPH
   } cpurs_op_e;

endpackage

// ---- src/cpurs_mac.sv ----
`timescale 1ns/1ns
module cpurs_mac #(
   parameter int W = cpurs_pkg::XLEN
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         mac_en,
   input  wire logic         wide,
   input  wire logic         sub,
   input  wire logic [W-1:0] op_a,
   input  wire logic [W-1:0] op_b,
   input  wire logic         load,
   input  wire logic [W-1:0] load_data,
   output logic      [W-1:0] acc
);

   // ======================================================================
   // product and sum
   logic [W-1:0] prod16;
   logic [W-1:0] prod32;
   logic [W-1:0] prod;
   logic [W-1:0] acc_nxt;
   logic [2*W-1:0] full32;

   assign prod16  = op_a[cpurs_pkg::HALF_W-1:0] * op_b[cpurs_pkg::HALF_W-1:0];
   assign full32  = op_a * op_b;
   assign prod32  = full32[W-1:0];
   assign prod    = wide ? prod32 : prod16;
   assign acc_nxt = sub ? acc - prod : acc + prod;

   // ======================================================================
   // accumulator
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc <= cpurs_pkg::ZERO_WORD;
      end else if (load) begin
         acc <= load_data;
      end else if (mac_en) begin
         acc <= acc_nxt;
      end
   end

endmodule

// ---- tb/cpurs_vec_mem.sv ----
`timescale 1ns/1ns
module cpurs_vec_mem #(
   parameter logic [31:0] SP_VAL = 32'h2000_0ff0,
   parameter logic [31:0] IP_VAL = 32'h0000_0410
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        mem_rd,
   input  wire logic [31:0] mem_addr,
   input  wire logic [3:0]  wait_cycles,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata
);
   logic [3:0]  cnt_r;
   logic [31:0] word_nxt;

   // ======================================================================
   // vector words, scrambled data when not answering
   assign word_nxt = (mem_addr == 32'h0000_0004) ? IP_VAL :
                     (mem_addr == 32'h0000_0000) ? SP_VAL :
                     ~mem_rdata;

   initial begin
      mem_ack   = 1'b0;
      mem_rdata = 32'h0000_0000;
      cnt_r     = 4'h0;
   end

   // one-cycle ack after wait_cycles idle cycles
   always @(posedge clk_sys) begin
      if (rst || mem_ack || !mem_rd) begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         cnt_r     <= 4'h0;
      end else if (cnt_r >= wait_cycles) begin
         mem_ack   <= 1'b1;
         mem_rdata <= word_nxt;
      end else begin
         cnt_r     <= cnt_r + 4'h1;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// ---- tb/test_cpu_reset_state_model.sv ----
`timescale 1ns/1ns
module test_cpu_reset_state_model;
   localparam logic [31:0] SP_V = 32'h2000_0ff0;
   localparam logic [31:0] IP_V = 32'h0000_0410;
   logic                 clk_sys;
   logic                 rst;
   logic                 cmd_valid;
   cpurs_pkg::cpurs_op_e cmd_op;
   logic [3:0]           cmd_sel;
   logic [31:0]          cmd_wdata;
   logic                 cmd_sub;
   logic                 cmd_ready;
   logic                 rsp_valid;
   logic [31:0]          rsp_data;
   logic                 priv_fault;
   logic                 mem_rd;
   logic [31:0]          mem_addr;
   logic                 mem_ack;
   logic [31:0]          mem_rdata;
   logic                 core_running;
   logic                 supervisor;
   logic [31:0]          ip_value;
   logic [31:0]          fast_port;
   logic [31:0]          periph_reg;
   logic [3:0]           mem_wait;
   logic                 got_rsp;
   logic                 got_flt;
   logic                 got_rdy;
   logic                 first_rdy;
   logic [31:0]          first_addr;
   logic [31:0]          got_data;
   int                   errors;
   int                   samples_checked;
   int                   cycles;

   cpurs_core_regs i_cpurs_core_regs (
      .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .cmd_sub(cmd_sub),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .priv_fault(priv_fault), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .core_running(core_running),
      .supervisor(supervisor), .ip_value(ip_value), .fast_port(fast_port),
      .periph_reg(periph_reg));

   cpurs_vec_mem #(.SP_VAL(SP_V), .IP_VAL(IP_V)) i_cpurs_vec_mem (
      .clk_sys(clk_sys), .rst(rst), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .wait_cycles(mem_wait), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // ======================================================================
   // clock, timeout, reporting
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ======================================================================
   // drivers
   task automatic cmd(input cpurs_pkg::cpurs_op_e op, input logic [3:0] sel,
                      input logic [31:0] wd, input logic sb);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_sel = sel;
      cmd_wdata = wd;
      cmd_sub = sb;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      @(posedge clk_sys);
      #1;
      got_rsp = rsp_valid;
      got_flt = priv_fault;
      got_rdy = cmd_ready;
      got_data = rsp_data;
      cmd_valid = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic do_reset(input logic [3:0] slow);
      int n;
      n = 0;
      mem_wait = slow;
      rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      @(posedge clk_sys);
      #1;
      first_rdy = cmd_ready;
      first_addr = mem_addr;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask

   // ======================================================================
   // scenarios
   task automatic t_reset_state();
      check({31'h0, first_rdy}, 32'h0);
      check(first_addr, 32'h0000_0000);
      check({29'h0, mem_rd, core_running, supervisor}, 32'h3);
      check(ip_value, IP_V);
      check(mem_addr, 32'h0000_0004);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_ALTSP}, 32'h0, 1'b0);
      check(got_data, SP_V);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_EXCB}, 32'h0, 1'b0);
      check(got_data, 32'h0000_0000);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_CFG}, 32'h0, 1'b0);
      check(got_data, 32'h0000_0000);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_STATE}, 32'h0, 1'b0);
      check(got_data, 32'h0000_0027);
      cmd(cpurs_pkg::OP_RD_GPR, 4'h0, 32'h0, 1'b0);
      check(got_data, cpurs_pkg::ID_WORD0);
      cmd(cpurs_pkg::OP_RD_GPR, 4'h1, 32'h0, 1'b0);
      check(got_data, cpurs_pkg::ID_WORD1);
   endtask

   task automatic t_regs_mac();
      cmd(cpurs_pkg::OP_WR_GPR, 4'hf, 32'ha5a5_0f0f, 1'b0);
      cmd(cpurs_pkg::OP_RD_GPR, 4'hf, 32'h0, 1'b0);
      check(got_data, 32'ha5a5_0f0f);
      cmd(cpurs_pkg::OP_WR_IP, 4'h0, 32'h0000_0800, 1'b0);
      check(ip_value, 32'h0000_0800);
      cmd(cpurs_pkg::OP_WR_FLAGS, 4'h0, 32'h0000_005a, 1'b0);
      cmd(cpurs_pkg::OP_RD_FLAGS, 4'h0, 32'h0, 1'b0);
      check({24'h0, got_data[7:0]}, 32'h0000_005a);
      cmd(cpurs_pkg::OP_WR_GPR, 4'h2, 32'h0001_0003, 1'b0);
      cmd(cpurs_pkg::OP_MAC16, 4'h2, 32'hffff_0004, 1'b0);
      cmd(cpurs_pkg::OP_MAC32, 4'h2, 32'h0000_0010, 1'b1);
      cmd(cpurs_pkg::OP_RD_ACC, 4'h0, 32'h0, 1'b0);
      check(got_data, 32'h0000_000c - 32'h0010_0030);
      cmd(cpurs_pkg::OP_WR_ACC, 4'h0, 32'h0000_0100, 1'b0);
      cmd(cpurs_pkg::OP_MAC16, 4'h2, 32'h0000_0010, 1'b1);
      cmd(cpurs_pkg::OP_RD_ACC, 4'h0, 32'h0, 1'b0);
      check(got_data, 32'h0000_00d0);
   endtask

   task automatic t_ports();
      int n;
      n = 0;
      cmd(cpurs_pkg::OP_WR_FAST, 4'h0, 32'h0000_1234, 1'b0);
      check({got_rdy, fast_port[30:0]}, 32'h8000_1234);
      cmd(cpurs_pkg::OP_WR_PERIPH, 4'h0, 32'h0000_cafe, 1'b0);
      check({31'h0, got_rdy}, 32'h0);
      while (periph_reg !== 32'h0000_cafe && n < 3) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(periph_reg, 32'h0000_cafe);
      cmd(cpurs_pkg::OP_RD_PERIPH, 4'h0, 32'h0, 1'b0);
      check(got_data, 32'h0000_cafe);
      cmd(cpurs_pkg::OP_RD_FAST, 4'h0, 32'h0, 1'b0);
      check(got_data, 32'h0000_1234);
   endtask

   task automatic t_priv();
      cmd(cpurs_pkg::OP_WR_CTRL, {2'h0, cpurs_pkg::CSEL_CFG}, 32'h0000_0055, 1'b0);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_CFG}, 32'h0, 1'b0);
      check({got_flt, got_data[30:0]}, 32'h0000_0055);
      cmd(cpurs_pkg::OP_WR_CTRL, {2'h0, cpurs_pkg::CSEL_EXCB}, 32'h0000_0400, 1'b0);
      cmd(cpurs_pkg::OP_WR_CTRL, {2'h0, cpurs_pkg::CSEL_ALTSP}, 32'h2000_0100, 1'b0);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_EXCB}, 32'h0, 1'b0);
      check(got_data, 32'h0000_0400);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_ALTSP}, 32'h0, 1'b0);
      check(got_data, 32'h2000_0100);
      cmd(cpurs_pkg::OP_WR_CTRL, {2'h0, cpurs_pkg::CSEL_STATE}, 32'h0000_0007, 1'b0);
      check({31'h0, supervisor}, 32'h0);
      cmd(cpurs_pkg::OP_WR_CTRL, {2'h0, cpurs_pkg::CSEL_STATE}, 32'h0000_0027, 1'b0);
      check({30'h0, got_flt, got_rsp}, 32'h2);
      check({31'h0, supervisor}, 32'h0);
      cmd(cpurs_pkg::OP_RD_CTRL, {2'h0, cpurs_pkg::CSEL_EXCB}, 32'h0, 1'b0);
      check({30'h0, got_flt, got_rsp}, 32'h2);
      cmd(cpurs_pkg::OP_RD_GPR, 4'hf, 32'h0, 1'b0);
      check({got_flt, got_rsp, got_data[29:0]}, 32'h65a5_0f0f);
   endtask

   // ======================================================================
   // main sequence
   initial begin
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      rst = 1'b1;
      mem_wait = 4'h0;
      cmd_valid = 1'b0;
      cmd_op = cpurs_pkg::OP_RD_GPR;
      cmd_sel = 4'h0;
      cmd_wdata = 32'h0;
      cmd_sub = 1'b0;
      #1;
      do_reset(4'h0);
      t_reset_state();
      t_regs_mac();
      t_ports();
      t_priv();
      do_reset(4'h3);
      t_reset_state();
      test_done();
   end
endmodule
